/* File: rtl/cpu_status_regs.sv */
// status, pointer and banked registers of the cpu core with an AXI4-Lite port
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module cpu_status_regs (
    input  wire logic                               core_clk,
    input  wire logic                               reset,
    // AXI4-Lite slave
    input  wire logic [cpu_status_pkg::AXI_AW-1:0]  awaddr,
    input  wire logic                               awvalid,
    output logic                                    awready,
    input  wire logic [cpu_status_pkg::AXI_DW-1:0]  wdata,
    input  wire logic [3:0]                         wstrb,
    input  wire logic                               wvalid,
    output logic                                    wready,
    output logic [1:0]                              bresp,
    output logic                                    bvalid,
    input  wire logic                               bready,
    input  wire logic [cpu_status_pkg::AXI_AW-1:0]  araddr,
    input  wire logic                               arvalid,
    output logic                                    arready,
    output logic [cpu_status_pkg::AXI_DW-1:0]       rdata,
    output logic [1:0]                              rresp,
    output logic                                    rvalid,
    input  wire logic                               rready,
    // instruction datapath
    input  wire logic                               nipLoad,
    input  wire logic [cpu_status_pkg::NIP_W-1:0]   nipNext,
    input  wire logic                               sbLoad,
    input  wire logic [cpu_status_pkg::WORD_W-1:0]  sbNext,
    input  wire logic                               flagLoad,
    input  wire logic [cpu_status_pkg::FLAG_W-1:0]  flagNext,
    input  wire logic                               aluFlagWe,
    input  wire logic [cpu_status_pkg::WORD_W-1:0]  aluResult,
    input  wire logic                               aluCarry,
    input  wire logic                               aluOverflow,
    input  wire logic                               stackPush,
    input  wire logic                               stackPop,
    input  wire logic                               spLoad,
    input  wire logic [cpu_status_pkg::WORD_W-1:0]  spNext,
    input  wire logic                               swTrap,
    input  wire logic [cpu_status_pkg::VEC_W-1:0]   trapVector,
    input  wire logic                               bankWe,
    input  wire logic [cpu_status_pkg::BIDX_W-1:0]  bankWrIdx,
    input  wire logic [cpu_status_pkg::WORD_W-1:0]  bankWrData,
    input  wire logic [cpu_status_pkg::BIDX_W-1:0]  bankRdIdx,
    output logic [cpu_status_pkg::WORD_W-1:0]       bankRdData,
    // interrupt sequencer
    input  wire logic                               irqRequest,
    input  wire logic                               irqMaskable,
    input  wire logic [cpu_status_pkg::PRIO_W-1:0]  irqPriority,
    input  wire logic                               irqAccept,
    output logic                                    irqGrant,
    // register views
    output logic [cpu_status_pkg::NIP_W-1:0]        nextInstructionPointer,
    output logic [cpu_status_pkg::WORD_W-1:0]       activeStackPointer,
    output logic [cpu_status_pkg::WORD_W-1:0]       staticBaseRegister,
    output logic [cpu_status_pkg::FLAG_W-1:0]       cpuStatusFlags
);
    import cpu_status_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // merge a bus write into a register, honouring byte strobes
    function automatic logic [AXI_DW-1:0] strobeMerge(
        input logic [AXI_DW-1:0] oldVal,
        input logic [AXI_DW-1:0] newVal,
        input logic [3:0]        strb
    );
        logic [AXI_DW-1:0] res;
        res = oldVal;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = newVal[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // true when the byte offset names a writable register
    function automatic logic isWritable(input logic [AXI_AW-1:0] a);
        return (a == OFS_NIP) || (a == OFS_USP) || (a == OFS_ISP) ||
               (a == OFS_SB) || (a == OFS_FLAGS);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [NIP_W-1:0]  nipQ,   nipD;
    logic [WORD_W-1:0] uspQ,   uspD;
    logic [WORD_W-1:0] ispQ,   ispD;
    logic [WORD_W-1:0] sbQ,    sbD;
    logic [FLAG_W-1:0] flagsQ, flagsD;

    logic              awHeldQ;
    logic [AXI_AW-1:0] awAddrQ;
    logic              wHeldQ;
    logic [AXI_DW-1:0] wDataQ;
    logic [3:0]        wStrbQ;
    logic              bValidQ;
    logic [1:0]        bRespQ;
    logic              rValidQ;
    logic [AXI_DW-1:0] rDataQ;
    logic [1:0]        rRespQ;

    // ------------------------------------------------------------
    // write channels
    // ------------------------------------------------------------
    // address and data are held separately so either may come first
    assign awready = ~awHeldQ;
    assign wready  = ~wHeldQ;
    assign bvalid  = bValidQ;
    assign bresp   = bRespQ;

    wire               wrFire  = awHeldQ & wHeldQ & ~bValidQ;
    wire               wrLegal = isWritable(awAddrQ);
    wire [AXI_DW-1:0]  wrWord;
    wire               busNip   = wrFire & (awAddrQ == OFS_NIP);
    wire               busUsp   = wrFire & (awAddrQ == OFS_USP);
    wire               busIsp   = wrFire & (awAddrQ == OFS_ISP);
    wire               busSb    = wrFire & (awAddrQ == OFS_SB);
    wire               busFlags = wrFire & (awAddrQ == OFS_FLAGS);
    wire [AXI_DW-1:0]  curWord;

    // current value of the addressed register, for partial strobes
    assign curWord = (awAddrQ == OFS_NIP)   ? {12'h000, nipQ} :
                     (awAddrQ == OFS_USP)   ? {16'h0000, uspQ} :
                     (awAddrQ == OFS_ISP)   ? {16'h0000, ispQ} :
                     (awAddrQ == OFS_SB)    ? {16'h0000, sbQ} :
                     (awAddrQ == OFS_FLAGS) ? {21'h0, flagsQ} :
                     32'h00000000;
    assign wrWord  = strobeMerge(curWord, wDataQ, wStrbQ);

    // holding registers and the write response
    always_ff @(posedge core_clk) begin
        if (reset) begin
            awHeldQ <= 1'b0;
            awAddrQ <= 8'h00;
            wHeldQ  <= 1'b0;
            wDataQ  <= 32'h00000000;
            wStrbQ  <= 4'h0;
            bValidQ <= 1'b0;
            bRespQ  <= RESP_OKAY;
        end else begin
            if (awvalid && !awHeldQ) begin
                awHeldQ <= 1'b1;
                awAddrQ <= {awaddr[AXI_AW-1:2], 2'b00};
            end
            if (wvalid && !wHeldQ) begin
                wHeldQ <= 1'b1;
                wDataQ <= wdata;
                wStrbQ <= wstrb;
            end
            if (wrFire) begin
                awHeldQ <= 1'b0;
                wHeldQ  <= 1'b0;
                bValidQ <= 1'b1;
                bRespQ  <= wrLegal ? RESP_OKAY : RESP_SLVERR;
            end else if (bValidQ && bready) begin
                bValidQ <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // stack pointer selection
    // ------------------------------------------------------------
    wire              userSel = flagsQ[FLG_U];
    wire [WORD_W-1:0] curSp   = userSel ? uspQ : ispQ;
    wire              spTouch = stackPush | stackPop | spLoad;
    wire [WORD_W-1:0] spMoved;

    // a simultaneous push and pop cancels; a load wins over both
    assign spMoved = spLoad ? spNext :
                     (stackPush & ~stackPop) ? curSp - SP_STEP :
                     (stackPop & ~stackPush) ? curSp + SP_STEP :
                     curSp;

    // only the pointer selected at the time of access moves
    always_comb begin
        uspD = uspQ;
        ispD = ispQ;
        if (busUsp) begin
            uspD = wrWord[WORD_W-1:0];
        end
        if (busIsp) begin
            ispD = wrWord[WORD_W-1:0];
        end
        if (spTouch && userSel) begin
            uspD = spMoved;
        end
        if (spTouch && !userSel) begin
            ispD = spMoved;
        end
    end

    // ------------------------------------------------------------
    // instruction pointer and static base
    // ------------------------------------------------------------
    // the datapath outranks software so a fetch update is never lost
    assign nipD = nipLoad ? nipNext :
                  busNip  ? wrWord[NIP_W-1:0] : nipQ;
    assign sbD  = sbLoad  ? sbNext :
                  busSb   ? wrWord[WORD_W-1:0] : sbQ;

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    wire lowTrap = swTrap & (trapVector < TRAP_HW_LIM);

    // later assignments take priority: events over loads over the bus
    always_comb begin
        flagsD = flagsQ;
        if (busFlags) begin
            flagsD = wrWord[FLAG_W-1:0];
        end
        if (flagLoad) begin
            flagsD = flagNext;
        end
        if (aluFlagWe) begin
            flagsD[FLG_C] = aluCarry;
            flagsD[FLG_Z] = (aluResult == 16'h0000);
            flagsD[FLG_S] = aluResult[WORD_W-1];
            flagsD[FLG_O] = aluOverflow;
        end
        if (irqAccept) begin
            flagsD[FLG_I] = 1'b0;
            flagsD[FLG_U] = 1'b0;
        end
        if (lowTrap) begin
            flagsD[FLG_U] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register update
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            nipQ   <= NIP_RST;
            uspQ   <= SP_RST;
            ispQ   <= SP_RST;
            sbQ    <= SB_RST;
            flagsQ <= FLAGS_RST;
        end else begin
            nipQ   <= nipD;
            uspQ   <= uspD;
            ispQ   <= ispD;
            sbQ    <= sbD;
            flagsQ <= flagsD;
        end
    end

    // ------------------------------------------------------------
    // register banks
    // ------------------------------------------------------------
    // writes to the spare eighth slot are dropped
    wire bankWrOk = bankWe & (bankWrIdx < BANK_REGS);

    reg_bank_mem u_banks (
        .core_clk (core_clk),
        .bankSel  (flagsQ[FLG_B]),
        .wrEn     (bankWrOk),
        .wrIdx    (bankWrIdx),
        .wrData   (bankWrData),
        .rdIdx    (bankRdIdx),
        .rdData   (bankRdData)
    );

    // ------------------------------------------------------------
    // interrupt gating
    // ------------------------------------------------------------
    irq_priority_gate u_gate (
        .irqRequest  (irqRequest),
        .irqMaskable (irqMaskable),
        .irqPriority (irqPriority),
        .intEnable   (flagsQ[FLG_I]),
        .threshold   (flagsQ[FLG_PHI:FLG_PLO]),
        .irqGrant    (irqGrant)
    );

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    wire [AXI_AW-1:0] rdAddr = {araddr[AXI_AW-1:2], 2'b00};
    wire              rdFire = arvalid & ~rValidQ;
    wire              rdHit;
    wire [AXI_DW-1:0] rdWord;

    assign arready = ~rValidQ;
    assign rvalid  = rValidQ;
    assign rdata   = rDataQ;
    assign rresp   = rRespQ;
    assign rdHit   = isWritable(rdAddr) || (rdAddr == OFS_ASP) ||
                     (rdAddr == OFS_IRQ);

    // reserved flag positions read back as zero
    assign rdWord = (rdAddr == OFS_NIP)   ? {12'h000, nipQ} :
                    (rdAddr == OFS_USP)   ? {16'h0000, uspQ} :
                    (rdAddr == OFS_ISP)   ? {16'h0000, ispQ} :
                    (rdAddr == OFS_SB)    ? {16'h0000, sbQ} :
                    (rdAddr == OFS_FLAGS) ? {21'h0, flagsQ} :
                    (rdAddr == OFS_ASP)   ? {16'h0000, curSp} :
                    (rdAddr == OFS_IRQ)   ? {31'h0, irqGrant} :
                    32'h00000000;

    // read data are captured when the address is taken
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rValidQ <= 1'b0;
            rDataQ  <= 32'h00000000;
            rRespQ  <= RESP_OKAY;
        end else if (rdFire) begin
            rValidQ <= 1'b1;
            rDataQ  <= rdWord;
            rRespQ  <= rdHit ? RESP_OKAY : RESP_SLVERR;
        end else if (rValidQ && rready) begin
            rValidQ <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register views
    // ------------------------------------------------------------
    // the debug bit is stored as written; keeping it zero is up to software
    assign nextInstructionPointer = nipQ;
    assign activeStackPointer     = curSp;
    assign staticBaseRegister     = sbQ;
    assign cpuStatusFlags         = flagsQ;

endmodule

/* File: rtl/cpu_status_pkg.sv */
// constants shared by the status and pointer register block
package cpu_status_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int NIP_W    = 20;
    localparam int WORD_W   = 16;
    localparam int FLAG_W   = 11;
    localparam int PRIO_W   = 3;
    localparam int BIDX_W   = 3;
    localparam int VEC_W    = 6;
    localparam int AXI_AW   = 8;
    localparam int AXI_DW   = 32;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [AXI_AW-1:0] OFS_NIP   = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_USP   = 8'h04;
    localparam logic [AXI_AW-1:0] OFS_ISP   = 8'h08;
    localparam logic [AXI_AW-1:0] OFS_SB    = 8'h0C;
    localparam logic [AXI_AW-1:0] OFS_FLAGS = 8'h10;
    localparam logic [AXI_AW-1:0] OFS_ASP   = 8'h14;
    localparam logic [AXI_AW-1:0] OFS_IRQ   = 8'h18;

    // ------------------------------------------------------------
    // flag field positions
    // ------------------------------------------------------------
    localparam int FLG_C    = 0;
    localparam int FLG_D    = 1;
    localparam int FLG_Z    = 2;
    localparam int FLG_S    = 3;
    localparam int FLG_B    = 4;
    localparam int FLG_O    = 5;
    localparam int FLG_I    = 6;
    localparam int FLG_U    = 7;
    localparam int FLG_PLO  = 8;
    localparam int FLG_PHI  = 10;

    // ------------------------------------------------------------
    // values after reset and step sizes
    // ------------------------------------------------------------
    localparam logic [NIP_W-1:0]  NIP_RST   = 20'h00000;
    localparam logic [WORD_W-1:0] SP_RST    = 16'h0000;
    localparam logic [WORD_W-1:0] SB_RST    = 16'h0000;
    localparam logic [FLAG_W-1:0] FLAGS_RST = 11'h000;
    localparam logic [WORD_W-1:0] SP_STEP   = 16'h0002;
    localparam logic [VEC_W-1:0]  TRAP_HW_LIM = 6'h20;
    localparam logic [BIDX_W-1:0] BANK_REGS = 3'h7;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: rtl/reg_bank_mem.sv */
// two banks of working registers with registered read data
`timescale 1ns/1ps
module reg_bank_mem (
    input  wire logic                                core_clk,
    input  wire logic                                bankSel,
    input  wire logic                                wrEn,
    input  wire logic [cpu_status_pkg::BIDX_W-1:0]   wrIdx,
    input  wire logic [cpu_status_pkg::WORD_W-1:0]   wrData,
    input  wire logic [cpu_status_pkg::BIDX_W-1:0]   rdIdx,
    output logic      [cpu_status_pkg::WORD_W-1:0]   rdData
);
    import cpu_status_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // one slot per bank is spare; no reset, contents are undefined
    logic [WORD_W-1:0] mem [0:15];
    wire  [3:0]        wrAddr = {bankSel, wrIdx};
    wire  [3:0]        rdAddr = {bankSel, rdIdx};

    // write port and registered read port share the bank select
    always_ff @(posedge core_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end

endmodule

/* File: rtl/irq_priority_gate.sv */
// decides whether a requested interrupt may be taken
`timescale 1ns/1ps
module irq_priority_gate (
    input  wire logic                              irqRequest,
    input  wire logic                              irqMaskable,
    input  wire logic [cpu_status_pkg::PRIO_W-1:0] irqPriority,
    input  wire logic                              intEnable,
    input  wire logic [cpu_status_pkg::PRIO_W-1:0] threshold,
    output logic                                   irqGrant
);
    import cpu_status_pkg::*;

    // ------------------------------------------------------------
    // gating
    // ------------------------------------------------------------
    // non-maskable requests bypass both the enable and the threshold
    wire aboveLevel = irqPriority > threshold;
    wire maskOpen   = intEnable & aboveLevel;

    assign irqGrant = irqRequest & (~irqMaskable | maskOpen);

endmodule

/* File: sim/cpu_status_regs_assertions.sv */
// concurrent checks on the status and pointer register block ports
`timescale 1ns/1ps
module cpu_status_regs_checker (
    input wire logic                               core_clk,
    input wire logic                               reset,
    input wire logic                               irqRequest,
    input wire logic                               irqMaskable,
    input wire logic [cpu_status_pkg::PRIO_W-1:0]  irqPriority,
    input wire logic                               irqAccept,
    input wire logic                               irqGrant,
    input wire logic                               swTrap,
    input wire logic [cpu_status_pkg::VEC_W-1:0]   trapVector,
    input wire logic                               aluFlagWe,
    input wire logic [cpu_status_pkg::WORD_W-1:0]  aluResult,
    input wire logic                               aluCarry,
    input wire logic                               aluOverflow,
    input wire logic                               nipLoad,
    input wire logic [cpu_status_pkg::NIP_W-1:0]   nipNext,
    input wire logic                               stackPush,
    input wire logic                               stackPop,
    input wire logic                               spLoad,
    input wire logic [cpu_status_pkg::WORD_W-1:0]  activeStackPointer,
    input wire logic [cpu_status_pkg::NIP_W-1:0]   nextInstructionPointer,
    input wire logic [cpu_status_pkg::FLAG_W-1:0]  cpuStatusFlags
);
    import cpu_status_pkg::*;
    // ------------------------------------------------------------
    // checks, all in the core clock domain
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_carry; aluFlagWe |=> cpuStatusFlags[FLG_C] == $past(aluCarry); endproperty
    a_carry: assert property (p_carry) else $error("carry flag mismatch");
    property p_zero; aluFlagWe |=> cpuStatusFlags[FLG_Z] == ($past(aluResult) == 16'h0); endproperty
    a_zero: assert property (p_zero) else $error("zero flag mismatch");
    property p_sign; aluFlagWe |=> cpuStatusFlags[FLG_S] == $past(aluResult[15]); endproperty
    a_sign: assert property (p_sign) else $error("sign flag mismatch");
    property p_ovf; aluFlagWe |=> cpuStatusFlags[FLG_O] == $past(aluOverflow); endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag mismatch");
    // maskable grant depends on enable flag and strict priority compare
    property p_grant; irqRequest && irqMaskable |->
        irqGrant == (cpuStatusFlags[FLG_I] && irqPriority > cpuStatusFlags[FLG_PHI:FLG_PLO]);
    endproperty
    a_grant: assert property (p_grant) else $error("grant wrong");
    property p_accept; irqAccept |=> !cpuStatusFlags[FLG_I] && !cpuStatusFlags[FLG_U]; endproperty
    a_accept: assert property (p_accept) else $error("accept left flags set");
    property p_trap; swTrap && trapVector < TRAP_HW_LIM |=> !cpuStatusFlags[FLG_U]; endproperty
    a_trap: assert property (p_trap) else $error("low trap kept user stack");
    property p_nip; nipLoad |=> nextInstructionPointer == $past(nipNext); endproperty
    a_nip: assert property (p_nip) else $error("pointer load lost");
    // a select change in the same cycle moves to the other pointer, so skip it
    property p_push; stackPush && !stackPop && !spLoad |=> $stable(cpuStatusFlags[FLG_U]) |->
        activeStackPointer == $past(activeStackPointer) - SP_STEP; endproperty
    a_push: assert property (p_push) else $error("push step wrong");
endmodule

bind cpu_status_regs cpu_status_regs_checker chk_i (.core_clk, .reset, .irqRequest,
    .irqMaskable, .irqPriority, .irqAccept, .irqGrant, .swTrap, .trapVector, .aluFlagWe,
    .aluResult, .aluCarry, .aluOverflow, .nipLoad, .nipNext, .stackPush, .stackPop, .spLoad,
    .activeStackPointer, .nextInstructionPointer, .cpuStatusFlags);

/* File: sim/testbench.sv */
// self-checking bench for the status and pointer register block
`timescale 1ns/1ps
module testbench;
    import cpu_status_pkg::*;
    logic        core_clk = 1'h0, reset = 1'h1;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
    logic        awready, wready, bvalid, arready, rvalid, irqGrant;
    logic [1:0]  bresp, rresp;
    logic        nipLoad = '0, sbLoad = '0, flagLoad = '0, aluFlagWe = '0, aluCarry = '0;
    logic        aluOverflow = '0, stackPush = '0, stackPop = '0, spLoad = '0, swTrap = '0;
    logic        bankWe = '0, irqRequest = '0, irqMaskable = '0, irqAccept = '0;
    logic [19:0] nipNext = '0, nextInstructionPointer;
    logic [15:0] sbNext = '0, aluResult = '0, spNext = '0, bankWrData = '0, bankRdData;
    logic [15:0] activeStackPointer, staticBaseRegister;
    logic [10:0] flagNext = '0, cpuStatusFlags;
    logic [5:0]  trapVector = '0;
    logic [2:0]  bankWrIdx = 3'h6, bankRdIdx = 3'h6, irqPriority = '0;
    logic [17:0] aluVec [3] = '{18'h20000, 18'h18000, 18'h07FFF};
    logic [10:0] aluExp [3] = '{11'h005, 11'h028, 11'h000};
    int          err_count = 0, n_compared = 0, cycles = 0;

    cpu_status_regs uut (.core_clk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .nipLoad, .nipNext, .sbLoad, .sbNext, .flagLoad, .flagNext,
        .aluFlagWe, .aluResult, .aluCarry, .aluOverflow, .stackPush, .stackPop, .spLoad,
        .spNext, .swTrap, .trapVector, .bankWe, .bankWrIdx, .bankWrData, .bankRdIdx,
        .bankRdData, .irqRequest, .irqMaskable, .irqPriority, .irqAccept, .irqGrant,
        .nextInstructionPointer, .activeStackPointer, .staticBaseRegister, .cpuStatusFlags);

    // ------------------------------------------------------------
    // clock, watchdog and helpers
    // ------------------------------------------------------------
    always #5 core_clk = ~core_clk;

    // a hung handshake ends the run here instead of spinning forever
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            final_report();
        end
    end

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // address and data offered together, each dropped once its ready is seen
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
        chk(32'(bresp), 32'(er));
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rready <= 1'h0;
        chk(rdata, ex);
        chk(32'(rresp), 32'(er));
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge core_clk);
        reset <= 1'h0;
        for (int i = 0; i < 5; i++) rdc(8'(4 * i), 32'h0, RESP_OKAY);
        rdc(8'h1C, 32'h0, RESP_SLVERR);
        axw(OFS_ASP, 32'h1, RESP_SLVERR);
        axw(OFS_USP, 32'h1234, RESP_OKAY);
        axw(OFS_ISP, 32'h5678, RESP_OKAY);
        rdc(OFS_ASP, 32'h5678, RESP_OKAY);
        axw(OFS_FLAGS, 32'h03C0, RESP_OKAY);
        rdc(OFS_FLAGS, 32'h3C0, RESP_OKAY);
        rdc(OFS_ASP, 32'h1234, RESP_OKAY);
        stackPush <= 1'h1;
        @(posedge core_clk) stackPush <= 1'h0;
        rdc(OFS_USP, 32'h1232, RESP_OKAY);
        // every priority level against a threshold of three
        irqRequest <= 1'h1;
        irqMaskable <= 1'h1;
        for (int p = 0; p < 8; p++) begin
            irqPriority <= 3'(p);
            @(posedge core_clk);
            chk(32'(irqGrant), 32'(p > 3));
        end
        irqAccept <= 1'h1;
        @(posedge core_clk) irqAccept <= 1'h0;
        @(posedge core_clk);
        chk(32'(cpuStatusFlags), 32'h300);
        chk(32'(irqGrant), 32'h0);
        chk(32'(activeStackPointer), 32'h5678);
        irqRequest <= 1'h0;
        stackPush <= 1'h1;
        @(posedge core_clk) stackPush <= 1'h0;
        rdc(OFS_ISP, 32'h5676, RESP_OKAY);
        stackPop <= 1'h1;
        @(posedge core_clk) stackPop <= 1'h0;
        @(posedge core_clk);
        chk(32'(activeStackPointer), 32'h5678);
        // traps at and below the hardware vector boundary
        axw(OFS_FLAGS, 32'h80, RESP_OKAY);
        for (int v = 32; v > 30; v--) begin
            swTrap <= 1'h1;
            trapVector <= 6'(v);
            @(posedge core_clk) swTrap <= 1'h0;
            @(posedge core_clk);
            chk(32'(cpuStatusFlags), (v == 32) ? 32'h80 : 32'h0);
        end
        for (int i = 0; i < 3; i++) begin
            {aluCarry, aluOverflow, aluResult} <= aluVec[i];
            aluFlagWe <= 1'h1;
            @(posedge core_clk) aluFlagWe <= 1'h0;
            @(posedge core_clk);
            chk(32'(cpuStatusFlags), 32'(aluExp[i]));
        end
        // same index in both banks, selected by the bank flag
        bankWe <= 1'h1;
        bankWrData <= 16'h1111;
        @(posedge core_clk) bankWe <= 1'h0;
        flagNext <= 11'h010;
        flagLoad <= 1'h1;
        @(posedge core_clk) flagLoad <= 1'h0;
        bankWe <= 1'h1;
        bankWrData <= 16'h2222;
        @(posedge core_clk) bankWe <= 1'h0;
        repeat (2) @(posedge core_clk);
        chk(32'(bankRdData), 32'h2222);
        flagNext <= 11'h000;
        flagLoad <= 1'h1;
        @(posedge core_clk) flagLoad <= 1'h0;
        repeat (2) @(posedge core_clk);
        chk(32'(bankRdData), 32'h1111);
        nipLoad <= 1'h1;
        nipNext <= 20'hFFFFF;
        sbLoad <= 1'h1;
        sbNext <= 16'hA5C3;
        @(posedge core_clk) nipLoad <= 1'h0;
        sbLoad <= 1'h0;
        rdc(OFS_NIP, 32'hFFFFF, RESP_OKAY);
        rdc(OFS_SB, 32'hA5C3, RESP_OKAY);
        wstrb <= 4'h1;
        axw(OFS_SB, 32'hFF, RESP_OKAY);
        wstrb <= 4'hF;
        rdc(OFS_SB, 32'hA5FF, RESP_OKAY);
        chk(32'(staticBaseRegister), 32'hA5FF);
        final_report();
    end
endmodule
